// ### bench/asrh_ctrl_bench.sv
/* bench for asrh_ctrl with a model sram. assumes model and checker compiled first. */
`timescale 1ns/1ps
module asrh_ctrl_bench;
    import asrh_pkg::*;
    logic clk_in = 0, nrst_in = 0, power_good_in = 0, req_valid_in = 0, req_write_in = 0;
    logic [ADDR_W-1:0] req_addr_in = '0, addr_lines_out;
    logic [DATA_W-1:0] req_wdata_in = '0, rsp_rdata_out, data_lines_in, data_lines_out, q;
    logic req_ready_out, rsp_valid_out, ready_out, chip_sel_n_out, out_gate_n_out;
    logic write_n_out, data_lines_oe_out, drv;
    int num_errors = 0, checked = 0;
    always #5 clk_in = ~clk_in;
    asrh_ctrl #(.LOCK_CYC(50)) dut_u (.clk_in, .nrst_in, .power_good_in, .req_valid_in,
        .req_write_in, .req_addr_in, .req_wdata_in, .req_ready_out, .rsp_valid_out,
        .rsp_rdata_out, .ready_out, .addr_lines_out, .chip_sel_n_out, .out_gate_n_out,
        .write_n_out, .data_lines_in, .data_lines_out, .data_lines_oe_out);
    asrh_sram_model mem_u (.pwr_in(power_good_in), .a_in(addr_lines_out),
        .cs_n_in(chip_sel_n_out), .oe_n_in(out_gate_n_out), .we_n_in(write_n_out),
        .d_in(data_lines_in), .q_out(q), .drv_out(drv));
    // a floating wire toggles on every clock edge so stale data never passes
    assign data_lines_in = data_lines_oe_out ? data_lines_out : drv ? q : {4{clk_in, !clk_in}};
    always @(negedge clk_in) if (data_lines_oe_out && drv) chk("clash", 1, 0);
    task chk(input string n, input logic [15:0] s, e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("FAIL %s exp %h got %h", n, e, s);
        end
    endtask
    task stop_test;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task acc(input logic w, input logic [14:0] a, input logic [7:0] d, input int t);
        int n;
        req_valid_in = 1;
        req_write_in = w;
        req_addr_in = a;
        req_wdata_in = d;
        @(negedge clk_in);
        req_valid_in = 0;
        n = 1;
        while (rsp_valid_out !== 1'b1 && n < 40) begin
            @(negedge clk_in);
            n++;
        end
        chk("lat", 16'(n), 16'(t));
        // next request is only legal three cycles after the answer
        repeat (3) @(negedge clk_in);
    endtask
    task t_lock;
        req_valid_in = 1;
        power_good_in = 1;
        repeat (50) @(negedge clk_in);
        chk("held req", chip_sel_n_out, 1);
        chk("lock", ready_out, 0);
        req_valid_in = 0;
        repeat (30) @(negedge clk_in);
        chk("unlock", ready_out, 1);
    endtask
    task t_rw;
        acc(1, 15'h7fff, 8'ha5, 23);
        acc(1, 15'h0000, 8'h3c, 23);
        acc(0, 15'h7fff, 8'h00, 15);
        chk("rd top", rsp_rdata_out, 8'ha5);
        acc(0, 15'h0000, 8'h00, 15);
        chk("rd low", rsp_rdata_out, 8'h3c);
    endtask
    task t_pf;
        fork
            acc(1, 15'h0001, 8'h99, 23);
            #80 power_good_in = 0;
        join
        chk("no take", req_ready_out, 0);
        t_lock;
        acc(0, 15'h7fff, 8'h00, 15);
        chk("kept", rsp_rdata_out, 8'ha5);
        acc(0, 15'h0001, 8'h00, 15);
        chk("pf write", rsp_rdata_out, 8'h99);
    endtask
    initial begin
        repeat (16) @(negedge clk_in);
        nrst_in = 1;
        t_lock;
        t_rw;
        t_pf;
        stop_test;
    end
    initial begin
        #50000;
        num_errors++;
        stop_test;
    end
endmodule

// ### bench/asrh_ctrl_sva.sv
/* port assertions for asrh_ctrl, bound below. assumes one clock domain. */
`timescale 1ns/1ps
module asrh_ctrl_sva (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic req_ready_out,
    input wire logic rsp_valid_out,
    input wire logic ready_out,
    input wire logic [asrh_pkg::ADDR_W-1:0] addr_lines_out,
    input wire logic chip_sel_n_out,
    input wire logic out_gate_n_out,
    input wire logic write_n_out,
    input wire logic data_lines_oe_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    property p_rd; !out_gate_n_out |-> write_n_out; endproperty
    a_rd: assert property (p_rd) else $error("strobe in read");
    property p_as; !chip_sel_n_out |-> $stable(addr_lines_out); endproperty
    a_as: assert property (p_as) else $error("addr moved");
    property p_ac; $changed(addr_lines_out) |-> chip_sel_n_out || write_n_out; endproperty
    a_ac: assert property (p_ac) else $error("addr in write");
    property p_dr; data_lines_oe_out |-> out_gate_n_out; endproperty
    a_dr: assert property (p_dr) else $error("drive clash");
    property p_lk; !ready_out && !$past(ready_out, 3) && chip_sel_n_out |=> chip_sel_n_out;
    endproperty
    a_lk: assert property (p_lk) else $error("taken in lockout");
    property p_wp; $fell(write_n_out) |-> !chip_sel_n_out ##16 $rose(write_n_out); endproperty
    a_wp: assert property (p_wp) else $error("write pulse");
    property p_wh; $rose(write_n_out) |-> data_lines_oe_out ##1 data_lines_oe_out; endproperty
    a_wh: assert property (p_wh) else $error("data hold");
    property p_rt; $fell(out_gate_n_out) |-> ##11 rsp_valid_out && $rose(out_gate_n_out); endproperty
    a_rt: assert property (p_rt) else $error("read time");
    c_rd: cover property ($fell(out_gate_n_out));
    c_wr: cover property ($fell(write_n_out));
    c_up: cover property ($rose(ready_out));
endmodule
bind asrh_ctrl asrh_ctrl_sva chk_u (.clk_in, .nrst_in, .req_ready_out, .rsp_valid_out, .ready_out,
    .addr_lines_out, .chip_sel_n_out, .out_gate_n_out, .write_n_out, .data_lines_oe_out);

// ### bench/asrh_sram_model.sv
/* behavioural battery-backed 32K x 8 sram. assumes the bench resolves the data wire. */
`timescale 1ns/1ps
module asrh_sram_model #(
    parameter int LOCK_NS = 400,
    parameter int PROT_NS = 40000
) (
    input wire logic pwr_in,
    input wire logic [14:0] a_in,
    input wire logic cs_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic [7:0] d_in,
    output logic [7:0] q_out,
    output logic drv_out
);
    logic [7:0] mem [32768];
    logic wr, live;
    logic up = 1'b0;
    logic hold = 1'b0;
    // short lockout in sim, still below the host's, so no access from the host arrives early
    always @(pwr_in) begin
        up = 1'b0;
        if (pwr_in) begin
            #(LOCK_NS);
            up = pwr_in;
        end
    end
    // a cycle under way at supply loss runs on until select rises or PROT_NS has passed
    always @(up or cs_n_in) begin
        if (up || cs_n_in) hold = up && !cs_n_in;
    end
    always @(negedge pwr_in) begin
        #(PROT_NS);
        if (!up) hold = 1'b0;
    end
    // without supply every new input is ignored and the pins float
    assign live = up || hold;
    assign wr = live && !cs_n_in && !we_n_in;
    always @(negedge wr) mem[a_in] = d_in;
    assign drv_out = live && !cs_n_in && !oe_n_in && we_n_in;
    assign q_out = mem[a_in];
endmodule

// ### hdl/asrh_ctrl.sv
/*
 * host controller driving an asynchronous 32K x 8 battery-backed sram.
 * one request at a time on the user side; the sram sees strobes only.
 * assumes the board resolves the data_lines wire from data_lines_oe_out.
 */
`timescale 1ns/1ps
module asrh_ctrl #(
    parameter int LOCK_CYC = asrh_pkg::LOCKOUT_CYC
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic power_good_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [asrh_pkg::ADDR_W-1:0] req_addr_in,
    input wire logic [asrh_pkg::DATA_W-1:0] req_wdata_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [asrh_pkg::DATA_W-1:0] rsp_rdata_out,
    output logic ready_out,
    output logic [asrh_pkg::ADDR_W-1:0] addr_lines_out,
    output logic chip_sel_n_out,
    output logic out_gate_n_out,
    output logic write_n_out,
    input wire logic [asrh_pkg::DATA_W-1:0] data_lines_in,
    output logic [asrh_pkg::DATA_W-1:0] data_lines_out,
    output logic data_lines_oe_out
);
    import asrh_pkg::*;
    asrh_state_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
    logic cs_n_q, cs_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, drv_q, drv_d;
    logic wr_q, wr_d, rsp_q, rsp_d;
    logic lock_ready;

    asrh_lockout #(.LOCK_CYC(LOCK_CYC)) u_lock (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .power_good_in(power_good_in),
        .ready_out(lock_ready)
    );

    // a request is taken only in idle with power settled
    assign req_ready_out = (st_q == ASRH_IDLE) && lock_ready;

    // request latch: address changes only with every strobe high
    // one request at a time: nothing new is taken until recovery ends
    always_comb begin
        addr_d = addr_q;
        wdat_d = wdat_q;
        wr_d = wr_q;
        if (st_q == ASRH_IDLE) begin
            if (req_valid_in && req_ready_out) begin
                addr_d = req_addr_in;
                wdat_d = req_wdata_in;
                wr_d = req_write_in;
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            addr_q <= '0;
            wdat_q <= '0;
            wr_q <= 1'b0;
        end else begin
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            wr_q <= wr_d;
        end
    end

    // read data taken on the edge that raises select and gate,
    // so the device is still driving when it is sampled
    always_comb begin
        rdat_d = rdat_q;
        rsp_d = 1'b0;
        unique case (st_q)
            ASRH_READ: begin
                if (cnt_q == 4'h0) begin
                    rdat_d = data_lines_in;
                    rsp_d = 1'b1;
                end
            end
            // write answers on the same edge that ends the hold phase and releases the pins
            ASRH_WHOLD: begin
                if (cnt_q == 4'h0) begin
                    rsp_d = 1'b1;
                end
            end
            default: begin
                rsp_d = 1'b0;
            end
        endcase
    end

    // rsp is a one-cycle pulse; rdat stands until the next read
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdat_q <= '0;
            rsp_q <= 1'b0;
        end else begin
            rdat_q <= rdat_d;
            rsp_q <= rsp_d;
        end
    end

    // sequencer and pin strobes; phases fixed for the slowest grade,
    // so faster parts are run no quicker than that
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        cs_n_d = cs_n_q;
        oe_n_d = oe_n_q;
        we_n_d = we_n_q;
        drv_d = drv_q;
        unique case (st_q)
            ASRH_IDLE: begin
                if (req_valid_in && req_ready_out) begin
                    cnt_d = SETUP_CYC;
                    st_d = ASRH_SETUP;
                end
            end
            ASRH_SETUP: begin
                if (cnt_q == 4'h0) begin
                    // address has been stable before select falls
                    cs_n_d = 1'b0;
                    if (wr_q) begin
                        // gate stays high so the device never drives
                        oe_n_d = 1'b1;
                        we_n_d = 1'b0;
                        drv_d = 1'b1;
                        cnt_d = WRITE_CYC;
                        st_d = ASRH_WRITE;
                    end else begin
                        oe_n_d = 1'b0;
                        we_n_d = 1'b1;
                        cnt_d = READ_CYC;
                        st_d = ASRH_READ;
                    end
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            ASRH_READ: begin
                if (cnt_q == 4'h0) begin
                    cs_n_d = 1'b1;
                    oe_n_d = 1'b1;
                    cnt_d = RECOV_CYC;
                    st_d = ASRH_RECOV;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            ASRH_WRITE: begin
                if (cnt_q == 4'h0) begin
                    // strobe rises first; data still held after it
                    we_n_d = 1'b1;
                    cnt_d = HOLD_CYC;
                    st_d = ASRH_WHOLD;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            ASRH_WHOLD: begin
                if (cnt_q == 4'h0) begin
                    cs_n_d = 1'b1;
                    drv_d = 1'b0;
                    cnt_d = RECOV_CYC;
                    st_d = ASRH_RECOV;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            ASRH_RECOV: begin
                // an access in progress always finishes, even on power loss
                if (cnt_q == 4'h0) begin
                    st_d = ASRH_IDLE;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            default: begin
                cs_n_d = 1'b1;
                oe_n_d = 1'b1;
                we_n_d = 1'b1;
                drv_d = 1'b0;
                st_d = ASRH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_q <= ASRH_IDLE;
            cnt_q <= CNT_RESET;
            cs_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            drv_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            cs_n_q <= cs_n_d;
            oe_n_q <= oe_n_d;
            we_n_q <= we_n_d;
            drv_q <= drv_d;
        end
    end

    // every pin comes straight from a flop, so strobes cannot glitch
    assign ready_out = lock_ready;
    assign addr_lines_out = addr_q;
    assign chip_sel_n_out = cs_n_q;
    assign out_gate_n_out = oe_n_q;
    assign write_n_out = we_n_q;
    assign data_lines_out = wdat_q;
    assign data_lines_oe_out = drv_q;
    assign rsp_valid_out = rsp_q;
    assign rsp_rdata_out = rdat_q;
endmodule

// ### hdl/asrh_lockout.sv
/*
 * power-good synchroniser and power-up lockout counter.
 * assumes power_good_in is asynchronous to clk_in.
 */
`timescale 1ns/1ps
module asrh_lockout #(
    parameter int LOCK_CYC = asrh_pkg::LOCKOUT_CYC
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic power_good_in,
    output logic ready_out
);
    import asrh_pkg::*;
    logic [2:0] sync_q, sync_d;
    logic good_q, good_d;
    logic [31:0] cnt_q, cnt_d;
    logic ready_q, ready_d;

    always_comb begin
        sync_d = {sync_q[1:0], power_good_in};
        good_d = good_q;
        // change counts only once stages two and three agree
        if (sync_q[2] == sync_q[1]) begin
            good_d = sync_q[2];
        end
        cnt_d = cnt_q;
        ready_d = ready_q;
        if (!good_q) begin
            cnt_d = '0;
            ready_d = 1'b0;
        end else if (cnt_q < 32'(LOCK_CYC)) begin
            cnt_d = cnt_q + 32'h1;
        end else begin
            ready_d = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync_q <= 3'h0;
            good_q <= 1'b0;
            cnt_q <= 32'h0;
            ready_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            good_q <= good_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
        end
    end

    assign ready_out = ready_q;
endmodule

// ### hdl/asrh_pkg.sv
/*
 * constants and state type for the host-side controller of a battery-backed
 * 32K x 8 asynchronous static ram with power-fail write protection.
 * assumes a single 100 MHz clock and an active-low asynchronous reset.
 */
package asrh_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int MEM_BYTES = 32768;
    localparam int CLK_MHZ = 100;
    // phase lengths minus one, in clock cycles (10 ns each), sized for the slowest grade
    localparam logic [3:0] SETUP_CYC = 4'h2;
    localparam logic [3:0] READ_CYC = 4'ha;
    localparam logic [3:0] GATE_CYC = 4'h2;
    localparam logic [3:0] WRITE_CYC = 4'hf;
    localparam logic [3:0] HOLD_CYC = 4'h2;
    localparam logic [3:0] RECOV_CYC = 4'h2;
    // power-up lockout: longest documented time, in ms, and its cycle count
    localparam int LOCKOUT_MS = 120;
    localparam int LOCKOUT_CYC = LOCKOUT_MS * 1000 * CLK_MHZ;
    localparam int PROTECT_MAX_US = 150;
    localparam int PROTECT_MIN_US = 40;
    localparam int PROTECT_MIN_CYC = PROTECT_MIN_US * CLK_MHZ;
    localparam logic [3:0] CNT_RESET = 4'h0;
    typedef enum logic [2:0] {
        ASRH_IDLE = 3'b000,
        ASRH_SETUP = 3'b001,
        ASRH_READ = 3'b010,
        ASRH_RGATE = 3'b011,
        ASRH_WRITE = 3'b100,
        ASRH_WHOLD = 3'b101,
        ASRH_RECOV = 3'b110
    } asrh_state_t;
endpackage
